// *** hdl/mcumap_pkg.sv ***
package mcumap_pkg;
    // ------------------------------------------------------------
    // Program space
    // ------------------------------------------------------------
    localparam logic [15:0] PROG_SIZE_LARGE   = 16'h2000;
    localparam logic [15:0] PROG_SIZE_MEDIUM  = 16'h1000;
    localparam logic [15:0] PROG_SIZE_SMALL   = 16'h0800;
    localparam logic [15:0] PROG_FACTORY_BASE = 16'h1e00;
    localparam logic [15:0] PROG_FACTORY_SIZE = 16'h0200;
    // ------------------------------------------------------------
    // Internal data space
    // ------------------------------------------------------------
    localparam logic [7:0]  IRAM_UPPER_BASE   = 8'h80;
    localparam logic [7:0]  BANK_REGION_TOP   = 8'h1f;
    localparam logic [7:0]  BIT_REGION_BASE   = 8'h20;
    localparam logic [7:0]  BIT_REGION_TOP    = 8'h2f;
    localparam int          BANK_SEL_LSB      = 3;
    localparam int          BANK_SEL_MSB      = 4;
    localparam logic [7:0]  STACK_PTR_RESET   = 8'h07;
    localparam logic [7:0]  PSW_RESET         = 8'h00;
    // ------------------------------------------------------------
    // On-chip external RAM and page control
    // ------------------------------------------------------------
    localparam logic [7:0]  ONCHIP_EXTERNAL_RAM_PAGE_CTRL_ADDR = 8'haa;
    localparam int          ONCHIP_EXTERNAL_RAM_PAGE_BIT_POS   = 0;
    localparam logic        ONCHIP_EXTERNAL_RAM_PAGE_RESET     = 1'b0;
    localparam int          ONCHIP_EXTERNAL_RAM_DEPTH          = 512;

    typedef enum logic [1:0] {
        MCUMAP_SP_IDLE = 2'b00,
        MCUMAP_SP_PUSH = 2'b01,
        MCUMAP_SP_POP  = 2'b10
    } mcumap_sp_op_t;
endpackage

// *** hdl/mcumap_ram.sv ***
`timescale 1ns/1ns
module mcumap_ram #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          ref_clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    // ------------------------------------------------------------
    // Flip-flop storage, registered read
    // ------------------------------------------------------------
    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        rdata_o <= mem_q[raddr_i];
    end
endmodule

// *** hdl/mcumap_top.sv ***
`timescale 1ns/1ns
// Behaviour
// - Decode 64 kB program space; largest variant stores 8192 bytes from zero.
// - Top 512 bytes of largest program store reserved for factory use.
// - Smaller variants implement 4096 or 2048 bytes of program storage.
// - Program memory is read-only; code reads return single bytes.
// - Internal RAM holds 256 bytes at addresses 0x00 to 0xff.
// - Lower 128 bytes reachable by direct and indirect addressing.
// - Above 0x7f, direct selects special function space, indirect upper RAM.
// - Lowest 32 bytes are four banks; status word bits pick one.
// - Indirect pointer comes from first or second register of active bank.
// - Bytes 0x20..0x2f also addressable as 128 bits, 8*offset plus bit.
// - Bit or byte access chosen by instruction operand kind.
// - Stack pointer marks last used slot; push writes pointer+1 then increments.
// - Reset loads stack pointer with 0x07; first push lands at 0x08.
// - Stack may sit anywhere in 256 bytes, up to 256 deep.
// - 512 bytes on-chip RAM mapped into external data space.
// - 8-bit external move takes upper address byte from page register.
// - 16-bit external move ignores upper seven bits; RAM repeats every 512.
// - Page register at 0xaa reads zero in bits 7..1, ignores writes there.
// - Page bit, reset zero, picks 256-byte page for 8-bit external moves.
// - Bank bits binary: bank n at 8*n, value 11 gives 0x18..0x1f.
// - Direct addresses 0x80..0xff go to special function space.
module mcumap_top #(
    parameter logic [15:0] PROG_SIZE = mcumap_pkg::PROG_SIZE_LARGE
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    // Program fetch / code read
    input  wire logic        prog_rd_i,
    input  wire logic [15:0] prog_addr_i,
    input  wire logic        prog_user_i,
    input  wire logic [7:0]  prog_rom_data_i,
    output logic      [12:0] prog_rom_addr_o,
    output logic             prog_hit_o,
    output logic             prog_fault_o,
    output logic      [7:0]  prog_data_o,
    // Internal data access
    input  wire logic        iram_req_i,
    input  wire logic        iram_we_i,
    input  wire logic        iram_indirect_i,
    input  wire logic        iram_use_reg_i,
    input  wire logic        iram_reg_sel_i,
    input  wire logic        iram_bit_i,
    input  wire logic [7:0]  iram_addr_i,
    input  wire logic [7:0]  iram_wdata_i,
    input  wire logic        iram_wbit_i,
    input  wire logic [7:0]  sfr_rdata_i,
    output logic             sfr_req_o,
    output logic             sfr_we_o,
    output logic      [7:0]  sfr_addr_o,
    output logic      [7:0]  sfr_wdata_o,
    output logic      [7:0]  iram_rdata_o,
    output logic             iram_rbit_o,
    // Stack
    input  wire logic        sp_push_i,
    input  wire logic        sp_pop_i,
    input  wire logic [7:0]  sp_push_data_i,
    output logic      [7:0]  stack_pointer_o,
    // External data
    input  wire logic        onchip_external_ram_req_i,
    input  wire logic        onchip_external_ram_we_i,
    input  wire logic        onchip_external_ram_wide_i,
    input  wire logic [15:0] data_pointer_i,
    input  wire logic [7:0]  onchip_external_ram_addr8_i,
    input  wire logic [7:0]  onchip_external_ram_wdata_i,
    output logic      [7:0]  onchip_external_ram_rdata_o,
    output logic      [8:0]  onchip_external_ram_index_o
);
    // ------------------------------------------------------------
    // Program memory decode
    // ------------------------------------------------------------
    logic prog_in_store;
    logic prog_in_factory;

    assign prog_in_store   = (prog_addr_i < PROG_SIZE);
    assign prog_in_factory = (PROG_SIZE == mcumap_pkg::PROG_SIZE_LARGE) &&
                             (prog_addr_i >= mcumap_pkg::PROG_FACTORY_BASE);
    assign prog_rom_addr_o = prog_addr_i[12:0];

    // Store has no write port: firmware can only read bytes from it
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            prog_hit_o   <= 1'b0;
            prog_fault_o <= 1'b0;
            prog_data_o  <= 8'h00;
        end else begin
            prog_hit_o   <= prog_rd_i && prog_in_store && !(prog_user_i && prog_in_factory);
            prog_fault_o <= prog_rd_i && (!prog_in_store || (prog_user_i && prog_in_factory));
            prog_data_o  <= (prog_rd_i && prog_in_store && !(prog_user_i && prog_in_factory)) ?
                            prog_rom_data_i : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Status word and stack pointer
    // ------------------------------------------------------------
    localparam logic [7:0] SP_ADDR  = 8'h81;
    localparam logic [7:0] PSW_ADDR = 8'hd0;

    logic [7:0]                program_status_word_q;
    logic [7:0]                stack_pointer_q;
    logic [1:0]                bank_q;
    mcumap_pkg::mcumap_sp_op_t sp_op;
    logic                      dir_sfr_wr;
    logic                      onchip_external_ram_page_bit_q;

    assign bank_q = program_status_word_q[mcumap_pkg::BANK_SEL_MSB:mcumap_pkg::BANK_SEL_LSB];
    assign sp_op  = sp_push_i ? mcumap_pkg::MCUMAP_SP_PUSH :
                    sp_pop_i  ? mcumap_pkg::MCUMAP_SP_POP  : mcumap_pkg::MCUMAP_SP_IDLE;
    assign stack_pointer_o = stack_pointer_q;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            program_status_word_q <= mcumap_pkg::PSW_RESET;
        end else if (dir_sfr_wr && iram_addr_i == PSW_ADDR && !iram_bit_i) begin
            program_status_word_q <= iram_wdata_i;
        end else if (dir_sfr_wr && iram_bit_i && iram_addr_i[7:3] == PSW_ADDR[7:3]) begin
            program_status_word_q[iram_addr_i[2:0]] <= iram_wbit_i;
        end
    end

    // Push wins over a direct pointer write in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            stack_pointer_q <= mcumap_pkg::STACK_PTR_RESET;
        end else begin
            case (sp_op)
                mcumap_pkg::MCUMAP_SP_PUSH: begin
                    stack_pointer_q <= stack_pointer_q + 8'h01;
                end
                mcumap_pkg::MCUMAP_SP_POP: begin
                    stack_pointer_q <= stack_pointer_q - 8'h01;
                end
                mcumap_pkg::MCUMAP_SP_IDLE: begin
                    if (dir_sfr_wr && !iram_bit_i && iram_addr_i == SP_ADDR) begin
                        stack_pointer_q <= iram_wdata_i;
                    end
                end
                default: begin
                    stack_pointer_q <= stack_pointer_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Internal RAM address decode
    // ------------------------------------------------------------
    logic [7:0] bank_reg_addr;
    logic [7:0] ptr_value;
    logic [7:0] byte_addr;
    logic       to_sfr;
    logic       iram_wr;
    logic [7:0] iram_wr_addr;
    logic [7:0] iram_wr_data;
    logic [7:0] iram_raw;
    logic [7:0] reg_raw;
    logic [7:0] byte_q;
    logic [2:0] bit_pos_q;
    logic       sfr_sel_q;
    logic       bit_q;

    // Bank n lives at 8*n
    assign bank_reg_addr = {3'b000, bank_q, 2'b00, iram_reg_sel_i};
    assign ptr_value     = reg_raw;
    // Bit address below 0x80 maps into 0x20..0x2f; higher ones map to special function byte {addr[7:3], 000}
    assign byte_addr = iram_bit_i ? (iram_addr_i[7] ? {iram_addr_i[7:3], 3'b000} :
                                     (mcumap_pkg::BIT_REGION_BASE + {4'h0, iram_addr_i[6:3]}))
                     : (iram_use_reg_i ? ptr_value : iram_addr_i);
    assign to_sfr    = !iram_indirect_i && !iram_use_reg_i &&
                       (byte_addr >= mcumap_pkg::IRAM_UPPER_BASE);
    assign dir_sfr_wr = iram_req_i && iram_we_i && to_sfr;

    // Live view of the pointer from the main array, so indirect decode costs no extra cycle
    logic [7:0] iram_mem_q [256];

    assign reg_raw = iram_mem_q[bank_reg_addr];

    assign iram_wr      = sp_push_i || (iram_req_i && iram_we_i && !to_sfr);
    assign iram_wr_addr = sp_push_i ? (stack_pointer_q + 8'h01) : byte_addr;
    assign iram_wr_data = sp_push_i ? sp_push_data_i :
                          iram_bit_i ? ((iram_mem_q[byte_addr] & ~(8'h01 << iram_addr_i[2:0])) |
                                        ({7'h00, iram_wbit_i} << iram_addr_i[2:0])) : iram_wdata_i;
    assign iram_raw     = iram_mem_q[byte_addr];

    always_ff @(posedge ref_clk_i) begin
        if (iram_wr) begin
            iram_mem_q[iram_wr_addr] <= iram_wr_data;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            byte_q    <= 8'h00;
            bit_pos_q <= 3'h0;
            sfr_sel_q <= 1'b0;
            bit_q     <= 1'b0;
        end else if (iram_req_i) begin
            byte_q    <= iram_raw;
            bit_pos_q <= iram_addr_i[2:0];
            sfr_sel_q <= to_sfr;
            bit_q     <= iram_bit_i;
        end
    end

    // Special function space and RAM both answer one cycle after the request
    logic [7:0] sfr_view;
    always_comb begin
        sfr_view = sfr_rdata_i;
        if (byte_addr == mcumap_pkg::ONCHIP_EXTERNAL_RAM_PAGE_CTRL_ADDR) begin
            sfr_view = {7'h00, onchip_external_ram_page_bit_q};
        end else if (byte_addr == SP_ADDR) begin
            sfr_view = stack_pointer_q;
        end else if (byte_addr == PSW_ADDR) begin
            sfr_view = program_status_word_q;
        end
    end

    logic [7:0] sfr_q;
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sfr_q <= 8'h00;
        end else if (iram_req_i && to_sfr) begin
            sfr_q <= sfr_view;
        end
    end

    assign iram_rdata_o = sfr_sel_q ? sfr_q : byte_q;
    assign iram_rbit_o  = iram_rdata_o[bit_pos_q] & bit_q;
    assign sfr_req_o    = iram_req_i && to_sfr;
    assign sfr_we_o     = dir_sfr_wr;
    assign sfr_addr_o   = byte_addr;
    assign sfr_wdata_o  = iram_wdata_i;

    // ------------------------------------------------------------
    // External RAM page control and decode
    // ------------------------------------------------------------
    logic [8:0] onchip_external_ram_index;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            onchip_external_ram_page_bit_q <= mcumap_pkg::ONCHIP_EXTERNAL_RAM_PAGE_RESET;
        end else if (dir_sfr_wr && !iram_bit_i && iram_addr_i == mcumap_pkg::ONCHIP_EXTERNAL_RAM_PAGE_CTRL_ADDR) begin
            onchip_external_ram_page_bit_q <= iram_wdata_i[mcumap_pkg::ONCHIP_EXTERNAL_RAM_PAGE_BIT_POS];
        end
    end

    assign onchip_external_ram_index = onchip_external_ram_wide_i ? data_pointer_i[8:0]
                                    : {onchip_external_ram_page_bit_q, onchip_external_ram_addr8_i};
    assign onchip_external_ram_index_o = onchip_external_ram_index;

    mcumap_ram #(.DEPTH(mcumap_pkg::ONCHIP_EXTERNAL_RAM_DEPTH), .AW(9)) u_onchip_external_ram (
        .ref_clk_i (ref_clk_i),
        .we_i      (onchip_external_ram_req_i && onchip_external_ram_we_i),
        .waddr_i   (onchip_external_ram_index),
        .wdata_i   (onchip_external_ram_wdata_i),
        .raddr_i   (onchip_external_ram_index),
        .rdata_o   (onchip_external_ram_rdata_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_push;
        sp_push_i;
    endsequence

    sequence s_pop;
        sp_pop_i && !sp_push_i;
    endsequence

    // Plain direct byte write; register checks add the address
    logic direct_byte_wr;
    assign direct_byte_wr = iram_req_i && iram_we_i && !iram_bit_i && !iram_indirect_i && !iram_use_reg_i;

    a_sp_push_step: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_push |=> stack_pointer_q == $past(stack_pointer_q) + 8'h01) else $error("push step wrong");

    a_push_lands: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_push |=> iram_mem_q[stack_pointer_q] == $past(sp_push_data_i)) else $error("push data misplaced");

    a_sp_pop_step: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        s_pop |=> stack_pointer_q == $past(stack_pointer_q) - 8'h01) else $error("pop step wrong");

    a_sp_reset_val: assert property (@(posedge ref_clk_i)
        $rose(resetn_i) |-> stack_pointer_q == 8'h07) else $error("sp reset wrong");

    a_reset_state: assert property (@(posedge ref_clk_i)
        $rose(resetn_i) |-> program_status_word_q == mcumap_pkg::PSW_RESET &&
        onchip_external_ram_page_bit_q == mcumap_pkg::ONCHIP_EXTERNAL_RAM_PAGE_RESET) else $error("status or page reset wrong");

    a_sp_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        direct_byte_wr && iram_addr_i == 8'h81 && !sp_push_i && !sp_pop_i
        |=> stack_pointer_q == $past(iram_wdata_i)) else $error("pointer write lost");

    a_bank_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        direct_byte_wr && iram_addr_i == 8'hd0
        |=> bank_q == $past(iram_wdata_i[4:3])) else $error("bank select write lost");

    a_page_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        direct_byte_wr && iram_addr_i == 8'haa
        |=> onchip_external_ram_page_bit_q == $past(iram_wdata_i[0])) else $error("page bit write lost");

    a_page_reads_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        iram_req_i && !iram_bit_i && !iram_indirect_i && !iram_use_reg_i && iram_addr_i == 8'haa
        |=> iram_rdata_o[7:1] == 7'h00) else $error("page high bits nonzero");

    a_wide_ignores_page: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        onchip_external_ram_wide_i |-> onchip_external_ram_index_o == data_pointer_i[8:0]) else $error("wide index wrong");

    a_narrow_uses_page: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !onchip_external_ram_wide_i |-> onchip_external_ram_index_o == {onchip_external_ram_page_bit_q, onchip_external_ram_addr8_i}) else $error("page index wrong");

    a_direct_high_sfr: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        iram_req_i && !iram_bit_i && !iram_indirect_i && !iram_use_reg_i && iram_addr_i[7]
        |-> sfr_req_o) else $error("direct high not sfr");

    a_direct_low_ram: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        iram_req_i && !iram_bit_i && !iram_use_reg_i && !iram_addr_i[7]
        |-> !sfr_req_o) else $error("low byte left ram");

    a_indirect_ram: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        iram_req_i && iram_indirect_i |-> !sfr_req_o) else $error("indirect hit sfr");

    a_reg_ptr_ram: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        iram_req_i && iram_use_reg_i |-> !sfr_req_o) else $error("register pointer hit sfr");

    a_bit_low_ram: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        iram_req_i && iram_bit_i && !iram_addr_i[7] |-> !sfr_req_o &&
        byte_addr == {4'h2, iram_addr_i[6:3]}) else $error("bit area misplaced");

    a_bit_high_sfr: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        iram_req_i && iram_bit_i && iram_addr_i[7]
        |-> sfr_req_o && sfr_addr_o == {iram_addr_i[7:3], 3'b000}) else $error("sfr bit byte wrong");

    a_code_read_byte: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        prog_rd_i && !prog_user_i && prog_addr_i < PROG_SIZE
        |=> prog_hit_o && prog_data_o == $past(prog_rom_data_i)) else $error("code byte wrong");

    a_factory_fault: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        prog_rd_i && prog_user_i && PROG_SIZE == 16'h2000 && prog_addr_i >= 16'h1e00
        |=> prog_fault_o && !prog_hit_o) else $error("factory area readable");

    a_store_bound: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        prog_rd_i && prog_addr_i >= PROG_SIZE |=> prog_fault_o) else $error("out of store hit");
endmodule

// *** verification/mcumap_far.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Code store and special function space seen by the block
// ------------------------------------------------------------
module mcumap_far (
    input  wire logic [12:0] prog_rom_addr_i,
    input  wire logic        sfr_req_i,
    input  wire logic [7:0]  sfr_addr_i,
    output logic      [7:0]  rom_data_o,
    output logic      [7:0]  sfr_rdata_o
);
    // Address-derived bytes, so a wrong index shows as wrong data
    assign rom_data_o  = prog_rom_addr_i[7:0] ^ {3'h0, prog_rom_addr_i[12:8]};
    // Unselected space shows a pattern, never a held value
    assign sfr_rdata_o = sfr_req_i ? ~sfr_addr_i : 8'h5a;
endmodule

// *** verification/mcumap_top_test.sv ***
`timescale 1ns/1ns
module mcumap_top_test;
    logic        ref_clk_i, resetn_i, prog_rd_i, prog_user_i, iram_req_i, iram_we_i, iram_indirect_i;
    logic        iram_use_reg_i, iram_reg_sel_i, iram_bit_i, iram_wbit_i, sp_push_i, sp_pop_i;
    logic        onchip_external_ram_req_i, onchip_external_ram_we_i, onchip_external_ram_wide_i, prog_hit_o, prog_fault_o, sfr_req_o, sfr_we_o, iram_rbit_o;
    logic [15:0] prog_addr_i, data_pointer_i;
    logic [7:0]  prog_rom_data_i, iram_addr_i, iram_wdata_i, sfr_rdata_i, sp_push_data_i, onchip_external_ram_addr8_i;
    logic [7:0]  onchip_external_ram_wdata_i, prog_data_o, sfr_addr_o, sfr_wdata_o, iram_rdata_o, stack_pointer_o, onchip_external_ram_rdata_o;
    logic [12:0] prog_rom_addr_o;
    logic [8:0]  onchip_external_ram_index_o;
    int          fails, checks_done;
    localparam logic [8:0] NO_RD = 9'h100;

    mcumap_top #(.PROG_SIZE(mcumap_pkg::PROG_SIZE_LARGE)) u_mcumap_top (
        .ref_clk_i, .resetn_i, .prog_rd_i, .prog_addr_i, .prog_user_i, .prog_rom_data_i, .prog_rom_addr_o,
        .prog_hit_o, .prog_fault_o, .prog_data_o, .iram_req_i, .iram_we_i, .iram_indirect_i, .iram_use_reg_i,
        .iram_reg_sel_i, .iram_bit_i, .iram_addr_i, .iram_wdata_i, .iram_wbit_i, .sfr_rdata_i, .sfr_req_o,
        .sfr_we_o, .sfr_addr_o, .sfr_wdata_o, .iram_rdata_o, .iram_rbit_o, .sp_push_i, .sp_pop_i,
        .sp_push_data_i, .stack_pointer_o, .onchip_external_ram_req_i, .onchip_external_ram_we_i, .onchip_external_ram_wide_i, .data_pointer_i,
        .onchip_external_ram_addr8_i, .onchip_external_ram_wdata_i, .onchip_external_ram_rdata_o, .onchip_external_ram_index_o);

    mcumap_far u_mcumap_far (.prog_rom_addr_i(prog_rom_addr_o), .sfr_req_i(sfr_req_o), .sfr_addr_i(sfr_addr_o),
        .rom_data_o(prog_rom_data_i), .sfr_rdata_o(sfr_rdata_i));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task complete_run;
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task step;
        @(posedge ref_clk_i);
        #1;
    endtask

    task prog(input logic [15:0] a, input logic u, input logic h);
        prog_addr_i = a;
        prog_user_i = u;
        prog_rd_i   = 1'b1;
        step;
        prog_rd_i = 1'b0;
        chk(prog_hit_o, h);
        chk(prog_fault_o, !h);
        chk(prog_data_o, h ? a[7:0] ^ {3'h0, a[12:8]} : 8'h00);
        step;
    endtask

    // s: expected special-function select, 2 skips; er[8] set skips the read check
    task iop(input logic we, ind, bt, input logic [7:0] a, wd, input logic [1:0] s, input logic [8:0] er);
        {iram_we_i, iram_indirect_i, iram_bit_i, iram_addr_i, iram_wdata_i, iram_wbit_i} = {we, ind, bt, a, wd, wd[0]};
        iram_req_i = 1'b1;
        #1;
        if (s != 2'd2) chk(sfr_req_o, s[0]);
        if (s == 2'd1) chk({sfr_we_o, sfr_addr_o}, {we, a});
        if (s == 2'd1) chk(sfr_wdata_o, wd);
        step;
        iram_req_i     = 1'b0;
        iram_use_reg_i = 1'b0;
        step;
        if (!er[8]) chk(bt ? {7'h0, iram_rbit_o} : iram_rdata_o, er[7:0]);
    endtask

    task xop(input logic we, wd16, input logic [15:0] dp, input logic [7:0] a8, wd, input logic [8:0] idx, rd);
        {onchip_external_ram_we_i, onchip_external_ram_wide_i, data_pointer_i, onchip_external_ram_addr8_i, onchip_external_ram_wdata_i} = {we, wd16, dp, a8, wd};
        onchip_external_ram_req_i = 1'b1;
        #1;
        chk(onchip_external_ram_index_o, idx);
        step;
        if (!rd[8]) chk(onchip_external_ram_rdata_o, rd[7:0]);
        onchip_external_ram_req_i = 1'b0;
        step;
    endtask

    task push(input logic [7:0] d);
        sp_push_data_i = d;
        sp_push_i      = 1'b1;
        step;
        sp_push_i = 1'b0;
        step;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_prog;
        prog(16'h0100, 1'b1, 1'b1);
        prog(16'h1dff, 1'b1, 1'b1);
        prog(16'h1e00, 1'b1, 1'b0);
        prog(16'h1fff, 1'b0, 1'b1);
        prog(16'h2000, 1'b0, 1'b0);
    endtask

    task t_iram;
        iop(1, 0, 0, 8'h30, 8'h5a, 0, NO_RD);
        iop(0, 1, 0, 8'h30, 8'h00, 0, 9'h05a);
        iop(1, 1, 0, 8'h90, 8'ha5, 0, NO_RD);
        iop(1, 0, 0, 8'h90, 8'h3c, 1, NO_RD);
        iop(0, 1, 0, 8'h90, 8'h00, 0, 9'h0a5);
        iop(0, 0, 0, 8'hff, 8'h00, 1, 9'h000);
        iop(1, 1, 0, 8'hff, 8'h81, 0, NO_RD);
        iop(0, 1, 0, 8'hff, 8'h00, 0, 9'h081);
    endtask

    task t_bank;
        for (int n = 0; n < 4; n++) begin
            iop(1, 0, 0, 8'hd0, 8'(n << 3), 2, NO_RD);
            iop(1, 0, 0, 8'(8 * n), 8'(8'h40 + n), 0, NO_RD);
            iop(1, 0, 0, 8'(8 * n + 1), 8'(8'h50 + n), 0, NO_RD);
            iop(1, 1, 0, 8'(8'h40 + n), 8'(8'h70 + n), 0, NO_RD);
            iop(1, 1, 0, 8'(8'h50 + n), 8'(8'h60 + n), 0, NO_RD);
            {iram_use_reg_i, iram_reg_sel_i} = 2'b10;
            iop(0, 1, 0, 8'h00, 8'h00, 2, 9'(8'h70 + n));
            {iram_use_reg_i, iram_reg_sel_i} = 2'b11;
            iop(0, 1, 0, 8'h00, 8'h00, 2, 9'(8'h60 + n));
        end
        iop(1, 0, 0, 8'hd0, 8'h00, 2, NO_RD);
    endtask

    task t_bit;
        iop(1, 0, 0, 8'h22, 8'h08, 0, NO_RD);
        iop(0, 0, 1, 8'h13, 8'h00, 0, 9'h001);
        iop(0, 0, 1, 8'h12, 8'h00, 0, 9'h000);
        iop(1, 0, 1, 8'h10, 8'h01, 0, NO_RD);
        iop(0, 0, 0, 8'h22, 8'h00, 0, 9'h009);
        iop(1, 0, 0, 8'h2f, 8'h00, 0, NO_RD);
        iop(1, 0, 1, 8'h7f, 8'h01, 0, NO_RD);
        iop(0, 0, 0, 8'h2f, 8'h00, 0, 9'h080);
        iop(1, 0, 1, 8'hd4, 8'h01, 2, NO_RD);
        iop(0, 0, 0, 8'hd0, 8'h00, 2, 9'h010);
        iop(0, 0, 1, 8'hd4, 8'h00, 2, 9'h001);
        iop(1, 0, 0, 8'hd0, 8'h00, 2, NO_RD);
    endtask

    task t_stack;
        push(8'h11);
        chk(stack_pointer_o, 8'h08);
        iop(0, 0, 0, 8'h08, 8'h00, 0, 9'h011);
        push(8'h22);
        iop(0, 1, 0, 8'h09, 8'h00, 0, 9'h022);
        sp_pop_i = 1'b1;
        step;
        sp_pop_i = 1'b0;
        step;
        chk(stack_pointer_o, 8'h08);
        iop(1, 0, 0, 8'h81, 8'hff, 2, NO_RD);
        push(8'h33);
        chk(stack_pointer_o, 8'h00);
        iop(0, 0, 0, 8'h00, 8'h00, 0, 9'h033);
    endtask

    // Page bit set, then cleared: the wide path must follow bit 8 only
    task t_onchip_external_ram;
        iop(1, 0, 0, 8'haa, 8'hff, 2, NO_RD);
        iop(0, 0, 0, 8'haa, 8'h00, 2, 9'h001);
        xop(1, 0, 16'h0000, 8'h10, 8'h3c, 9'h110, NO_RD);
        xop(0, 1, 16'hff10, 8'h10, 8'h00, 9'h110, 9'h03c);
        iop(1, 0, 0, 8'haa, 8'hfe, 2, NO_RD);
        iop(0, 0, 0, 8'haa, 8'h00, 2, 9'h000);
        xop(1, 0, 16'hffff, 8'h10, 8'hc3, 9'h010, NO_RD);
        xop(0, 1, 16'h0210, 8'h55, 8'h00, 9'h010, 9'h0c3);
        xop(0, 1, 16'h0110, 8'h10, 8'h00, 9'h110, 9'h03c);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {prog_rd_i, prog_user_i, iram_req_i, iram_we_i, iram_indirect_i, iram_use_reg_i} = '0;
        {iram_reg_sel_i, iram_bit_i, iram_wbit_i, sp_push_i, sp_pop_i, onchip_external_ram_req_i, onchip_external_ram_we_i, onchip_external_ram_wide_i} = '0;
        {prog_addr_i, data_pointer_i, iram_addr_i, iram_wdata_i, sp_push_data_i, onchip_external_ram_addr8_i, onchip_external_ram_wdata_i} = '0;
        fails       = 0;
        checks_done = 0;
        resetn_i    = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        resetn_i = 1'b1;
        chk(stack_pointer_o, 8'h07);
        iop(0, 0, 0, 8'haa, 8'h00, 2, 9'h000);
        t_prog;
        t_iram;
        t_bank;
        t_bit;
        t_stack;
        t_onchip_external_ram;
        complete_run;
    end

    // Whole run is about 150 cycles; this cuts off a hung simulation
    initial begin
        #50000;
        fails++;
        complete_run;
    end
endmodule
